/* File: lbecu_bus_if.sv */
`timescale 1ns/1ps
interface lbecu_bus_if;
  import lbecu_pkg::*;
  logic                 address_strobe_n;
  logic [WADDR_W-1:0]   word_address_lines;
  logic                 write_not_read;
  logic                 same_page_hint_n;
  logic                 page_table_attr;
  logic [LANES-1:0]     byte_lane_enable_n;
  logic [DATA_W-1:0]    dev_data_out;
  logic                 dev_data_oe;
  logic [DATA_W-1:0]    mem_data_out;
  logic                 mem_data_oe;
  logic                 cycle_ready_n;
  logic                 next_addr_ok_n;
  // resolved data_lines level; undriven reads as zero
  logic [DATA_W-1:0]    data_lines;
  assign data_lines = dev_data_oe ? dev_data_out :
                      (mem_data_oe ? mem_data_out : '0);

  modport device (
    output address_strobe_n, word_address_lines, write_not_read,
    output same_page_hint_n, page_table_attr, byte_lane_enable_n,
    output dev_data_out, dev_data_oe,
    input  data_lines, cycle_ready_n, next_addr_ok_n
  );
  modport memory (
    input  address_strobe_n, word_address_lines, write_not_read,
    input  same_page_hint_n, page_table_attr, byte_lane_enable_n,
    input  data_lines,
    output mem_data_out, mem_data_oe, cycle_ready_n, next_addr_ok_n
  );
endinterface

/* File: lbecu_checker.sv */
`timescale 1ns/1ps
module lbecu_checker
  import lbecu_pkg::*;
(
  // clock and reset
  input wire logic               clock_i,
  input wire logic               reset_n_i,
  // link signals
  input wire logic               address_strobe_n,
  input wire logic [WADDR_W-1:0] word_address_lines,
  input wire logic               write_not_read,
  input wire logic [LANES-1:0]   byte_lane_enable_n,
  input wire logic               dev_data_oe,
  input wire logic               mem_data_oe,
  input wire logic               cycle_ready_n
);
  logic busy_reg;
  logic last_rd_reg;

  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  ////////////////////////////////////////
  // open from strobe to the clock of ready
  always_ff @(posedge clock_i) begin
    if (!reset_n_i)
      busy_reg <= 1'b0;
    else if (!address_strobe_n)
      busy_reg <= 1'b1;
    else if (!cycle_ready_n)
      busy_reg <= 1'b0;
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i)
      last_rd_reg <= 1'b0;
    else if (!cycle_ready_n)
      last_rd_reg <= !write_not_read;
  end

  ////////////////////////////////////////
  a_strobe_single: assert property (
    !address_strobe_n |=> address_strobe_n [*2])
    else $error("strobe held or repeated too soon");
  a_cycle_stable: assert property (
    busy_reg |-> $stable(word_address_lines) && $stable(write_not_read)
      && $stable(byte_lane_enable_n))
    else $error("cycle signals moved before ready");
  a_read_float: assert property (
    busy_reg && !write_not_read |-> !dev_data_oe)
    else $error("device drove data in a read");
  a_write_drive: assert property (
    !address_strobe_n && write_not_read |-> ##2 dev_data_oe)
    else $error("write data not driven in data wait");
  a_no_contention: assert property (
    !(dev_data_oe && mem_data_oe))
    else $error("both ends drive data");
  a_wr_after_rd: assert property (
    !address_strobe_n && write_not_read && last_rd_reg |-> !dev_data_oe)
    else $error("write data driven in address phase after read");
  a_ready_bound: assert property (
    !address_strobe_n |-> ##[1:40] !cycle_ready_n)
    else $error("no ready after strobe");
  a_ready_owned: assert property (
    $fell(cycle_ready_n) |-> busy_reg)
    else $error("ready outside a cycle");
endmodule

/* File: lbecu_device.sv */
`timescale 1ns/1ps
module lbecu_device
  import lbecu_pkg::*;
(
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              reset_n_i,
  // endian control
  input  wire logic              supervisor_i,
  input  wire logic              set_endian_i,
  input  wire logic              big_endian_sel_i,
  output logic                   big_endian_o,
  // internal request
  input  wire logic              req_valid_i,
  input  wire logic              req_write_i,
  input  wire logic              req_fetch_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire lbecu_size_type    req_size_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  input  wire logic              req_same_page_i,
  input  wire logic              req_pt_attr_i,
  output logic                   req_ready_o,
  // load return
  output logic                   load_valid_o,
  output logic [DATA_W-1:0]      load_data_o,
  // link
  lbecu_bus_if.device            bus
);
  lbecu_state_type        state_reg;
  logic                   big_endian_reg;
  logic                   cyc_big_reg;
  logic [OFS_W-1:0]       cyc_ofs_reg;
  lbecu_size_type         cyc_size_reg;
  logic                   last_read_reg;
  logic                   na_latched_reg;
  logic [OUT_CNT_W-1:0]   outst_reg;
  logic                   take;
  logic                   done;
  logic                   eff_big;
  logic [DATA_W-1:0]      steer_store;
  logic [DATA_W-1:0]      steer_load;
  logic [LANES-1:0]       steer_mask;

  ////////////////////////////////////////////////////////////////////////
  // link inputs come from logic on clock_i and are used as sampled

  ////////////////////////////////////////////////////////////////////////
  // endian mode
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      big_endian_reg <= 1'b0;
    end else if (set_endian_i && supervisor_i) begin
      big_endian_reg <= big_endian_sel_i;
    end
  end

  assign eff_big = big_endian_reg && !req_fetch_i;

  lbecu_steer u_steer (
    .offset_i     (req_addr_i[OFS_W-1:0]),
    .size_i       (req_size_i),
    .big_endian_i (eff_big),
    .store_data_i (req_wdata_i),
    .bus_data_i   (bus.data_lines),
    .store_bus_o  (steer_store),
    .load_data_o  (),
    .lane_mask_o  (steer_mask)
  );

  // loads steer with the offset, size and mode captured at take
  lbecu_steer u_steer_load (
    .offset_i     (cyc_ofs_reg),
    .size_i       (cyc_size_reg),
    .big_endian_i (cyc_big_reg),
    .store_data_i (req_wdata_i),
    .bus_data_i   (bus.data_lines),
    .store_bus_o  (),
    .load_data_o  (steer_load),
    .lane_mask_o  ()
  );

  ////////////////////////////////////////////////////////////////////////
  // bus cycle state machine
  // a request is taken only from idle or on completion, so at most one
  // cycle is outstanding and starts are never back to back
  assign done = (state_reg == LBECU_ST_WAIT) && !bus.cycle_ready_n;
  assign take = req_valid_i && (state_reg == LBECU_ST_IDLE || done)
                && (outst_reg - (done ? OUT_ONE : 2'h0) < 2'(MAX_OUTST))
                && !(req_write_i && last_read_reg && done);
  assign req_ready_o = take;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state_reg <= LBECU_ST_IDLE;
    end else begin
      unique case (state_reg)
        LBECU_ST_IDLE: if (take) state_reg <= LBECU_ST_ADDR;
        LBECU_ST_ADDR: state_reg <= LBECU_ST_WAIT;
        LBECU_ST_WAIT: begin
          if (done) begin
            state_reg <= take ? LBECU_ST_ADDR : LBECU_ST_IDLE;
          end else begin
            state_reg <= LBECU_ST_WAIT;
          end
        end
        default: state_reg <= LBECU_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      outst_reg <= '0;
    end else begin
      outst_reg <= OUT_CNT_W'(outst_reg + (take ? OUT_ONE : 2'h0)
                   - (done ? OUT_ONE : 2'h0));
    end
  end

  // next address ok is latched only while strobe inactive, cleared at completion or in idle; nothing reads it
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      na_latched_reg <= 1'b0;
    end else if (done || state_reg == LBECU_ST_IDLE) begin
      na_latched_reg <= 1'b0;
    end else if (!bus.next_addr_ok_n && bus.address_strobe_n) begin
      na_latched_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cycle signals except the one-clock strobe and the data enable, held until completion
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      bus.address_strobe_n   <= 1'b1;
      bus.word_address_lines <= '0;
      bus.write_not_read     <= 1'b0;
      bus.same_page_hint_n   <= 1'b1;
      bus.page_table_attr    <= 1'b0;
      bus.byte_lane_enable_n <= '1;
      bus.dev_data_out       <= '0;
      bus.dev_data_oe        <= 1'b0;
      cyc_big_reg            <= 1'b0;
      cyc_ofs_reg            <= '0;
      cyc_size_reg           <= LBECU_SZ_BYTE;
      last_read_reg          <= 1'b0;
    end else begin
      bus.address_strobe_n <= !take;
      if (take) begin
        bus.word_address_lines <= req_addr_i[ADDR_W-1:OFS_W];
        bus.write_not_read     <= req_write_i;
        bus.same_page_hint_n   <= !req_same_page_i;
        bus.page_table_attr    <= req_pt_attr_i;
        bus.byte_lane_enable_n <= ~steer_mask;
        bus.dev_data_out       <= steer_store;
        bus.dev_data_oe        <= req_write_i && !last_read_reg;
        cyc_big_reg            <= eff_big;
        cyc_ofs_reg            <= req_addr_i[OFS_W-1:0];
        cyc_size_reg           <= req_size_i;
        last_read_reg          <= !req_write_i;
      end else if (state_reg == LBECU_ST_ADDR && bus.write_not_read) begin
        bus.dev_data_oe <= 1'b1;
      end else if (done) begin
        bus.dev_data_oe <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // load return and status
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      load_valid_o <= 1'b0;
      load_data_o  <= '0;
      big_endian_o <= 1'b0;
    end else begin
      load_valid_o <= done && !bus.write_not_read;
      if (done && !bus.write_not_read) begin
        load_data_o <= steer_load;
      end
      big_endian_o <= big_endian_reg;
    end
  end
endmodule

/* File: lbecu_memory.sv */
`timescale 1ns/1ps
module lbecu_memory
  import lbecu_pkg::*;
(
  // clock and reset
  input  wire logic               clock_i,
  input  wire logic               reset_n_i,
  // user side
  input  wire logic [DATA_W-1:0]  rd_data_i,
  input  wire logic               wait_req_i,
  output logic                    wr_valid_o,
  output logic [WADDR_W-1:0]      wr_addr_o,
  output logic [DATA_W-1:0]       wr_data_o,
  output logic [LANES-1:0]        wr_lanes_o,
  // link
  lbecu_bus_if.memory             bus
);
  logic busy_reg;
  logic extra_reg;
  logic prev_read_reg;

  assign bus.next_addr_ok_n = 1'b1;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      busy_reg          <= 1'b0;
      extra_reg         <= 1'b0;
      prev_read_reg     <= 1'b0;
      bus.cycle_ready_n <= 1'b1;
      bus.mem_data_oe   <= 1'b0;
      bus.mem_data_out  <= '0;
      wr_valid_o        <= 1'b0;
      wr_addr_o         <= '0;
      wr_data_o         <= '0;
      wr_lanes_o        <= '0;
    end else begin
      bus.cycle_ready_n <= 1'b1;
      bus.mem_data_oe   <= 1'b0;
      wr_valid_o        <= 1'b0;
      if (!bus.address_strobe_n) begin
        busy_reg  <= 1'b1;
        extra_reg <= bus.write_not_read && prev_read_reg;
      end else if (busy_reg && extra_reg) begin
        extra_reg <= 1'b0;
      end else if (busy_reg && !wait_req_i) begin
        busy_reg          <= 1'b0;
        bus.cycle_ready_n <= 1'b0;
        prev_read_reg     <= !bus.write_not_read;
        if (bus.write_not_read) begin
          wr_valid_o <= 1'b1;
          wr_addr_o  <= bus.word_address_lines;
          wr_data_o  <= bus.data_lines;
          wr_lanes_o <= ~bus.byte_lane_enable_n;
        end else begin
          bus.mem_data_oe  <= 1'b1;
          bus.mem_data_out <= rd_data_i;
        end
      end
    end
  end
endmodule

/* File: lbecu_pkg.sv */
package lbecu_pkg;
  localparam int ADDR_W       = 32;
  localparam int WADDR_W      = 29;
  localparam int DATA_W       = 64;
  localparam int LANES        = 8;
  localparam int OFS_W        = 3;
  localparam int MAX_OUTST    = 3;
  localparam int OUT_CNT_W    = 2;
  localparam logic [2:0] BIG_END_XOR = 3'h7;
  localparam logic [1:0] OUT_ONE     = 2'h1;

  // access size codes
  typedef enum logic [1:0] {
    LBECU_SZ_BYTE = 2'b00,
    LBECU_SZ_HALF = 2'b01,
    LBECU_SZ_WORD = 2'b10,
    LBECU_SZ_DBL  = 2'b11
  } lbecu_size_type;

  typedef enum logic [1:0] {
    LBECU_ST_IDLE = 2'b00,
    LBECU_ST_ADDR = 2'b01,
    LBECU_ST_WAIT = 2'b10
  } lbecu_state_type;
endpackage

/* File: lbecu_steer.sv */
`timescale 1ns/1ps
module lbecu_steer
  import lbecu_pkg::*;
(
  // access description
  input  wire logic [OFS_W-1:0]  offset_i,
  input  wire lbecu_size_type    size_i,
  input  wire logic              big_endian_i,
  // data paths
  input  wire logic [DATA_W-1:0] store_data_i,
  input  wire logic [DATA_W-1:0] bus_data_i,
  output logic      [DATA_W-1:0] store_bus_o,
  output logic      [DATA_W-1:0] load_data_o,
  output logic      [LANES-1:0]  lane_mask_o
);
  logic [OFS_W-1:0] nbytes_m1;
  logic [OFS_W-1:0] shift;
  logic [LANES-1:0] base_mask;

  always_comb begin
    unique case (size_i)
      LBECU_SZ_BYTE: nbytes_m1 = 3'h0;
      LBECU_SZ_HALF: nbytes_m1 = 3'h1;
      LBECU_SZ_WORD: nbytes_m1 = 3'h3;
      LBECU_SZ_DBL:  nbytes_m1 = 3'h7;
    endcase
  end

  // big endian inverts the offset of the item's last byte (xor 7)
  always_comb begin
    if (big_endian_i) begin
      shift = (offset_i + nbytes_m1) ^ BIG_END_XOR;
    end else begin
      shift = offset_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_mask
      assign base_mask[g] = (g <= int'(nbytes_m1));
    end
  endgenerate

  assign lane_mask_o = LANES'(base_mask << shift);
  assign store_bus_o = store_data_i << {shift, 3'h0};
  assign load_data_o = bus_data_i >> {shift, 3'h0};
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench
  import lbecu_pkg::*;
;
  localparam logic [63:0] RD = 64'h8877_6655_4433_2211;
  localparam logic [63:0] WD = 64'hf1e2_d3c4_b5a6_9788;
  localparam logic [28:0] WA = 29'h1abc_def1;
  logic               clock_i, reset_n_i, supervisor_i, set_endian_i;
  logic               big_endian_sel_i, big_endian_o, req_valid_i;
  logic               req_write_i, req_fetch_i, req_same_page_i;
  logic               req_pt_attr_i, req_ready_o, load_valid_o;
  logic               wait_req_i, wr_valid_o;
  logic [ADDR_W-1:0]  req_addr_i;
  lbecu_size_type     req_size_i;
  logic [DATA_W-1:0]  req_wdata_i, load_data_o, rd_data_i, wr_data_o;
  logic [WADDR_W-1:0] wr_addr_o;
  logic [LANES-1:0]   wr_lanes_o;
  int                 n_fail = 0;
  int                 tests_run = 0;
  int                 cyc = 0;

  lbecu_bus_if bus_if ();
  lbecu_device u_lbecu_device (
    .clock_i, .reset_n_i, .supervisor_i, .set_endian_i,
    .big_endian_sel_i, .big_endian_o, .req_valid_i, .req_write_i,
    .req_fetch_i, .req_addr_i, .req_size_i, .req_wdata_i,
    .req_same_page_i, .req_pt_attr_i, .req_ready_o, .load_valid_o,
    .load_data_o, .bus (bus_if)
  );
  lbecu_memory u_lbecu_memory (
    .clock_i, .reset_n_i, .rd_data_i, .wait_req_i, .wr_valid_o,
    .wr_addr_o, .wr_data_o, .wr_lanes_o, .bus (bus_if)
  );
  lbecu_checker u_lbecu_checker (
    .clock_i, .reset_n_i,
    .address_strobe_n   (bus_if.address_strobe_n),
    .word_address_lines (bus_if.word_address_lines),
    .write_not_read     (bus_if.write_not_read),
    .byte_lane_enable_n (bus_if.byte_lane_enable_n),
    .dev_data_oe        (bus_if.dev_data_oe),
    .mem_data_oe        (bus_if.mem_data_oe),
    .cycle_ready_n      (bus_if.cycle_ready_n)
  );

  always #12.5 clock_i = ~clock_i;

  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      test_done();
    end
  end

  ////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk64(input string nm, input logic [63:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic set_mode(input logic sup, big);
    @(posedge clock_i);
    supervisor_i <= sup;
    set_endian_i <= 1'b1;
    big_endian_sel_i <= big;
    @(posedge clock_i);
    set_endian_i <= 1'b0;
    repeat (2) @(negedge clock_i);
  endtask

  // hold the request until the edge that takes it
  task automatic put(input logic w, f, input logic [31:0] a,
                     input lbecu_size_type s);
    int k;
    @(posedge clock_i);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_fetch_i <= f;
    req_addr_i <= a;
    req_size_i <= s;
    req_wdata_i <= WD;
    req_same_page_i <= a[3];
    req_pt_attr_i <= w;
    k = 0;
    do begin
      @(negedge clock_i);
      k++;
    end while (req_ready_o !== 1'b1 && k < 60);
    @(posedge clock_i);
    req_valid_i <= 1'b0;
  endtask

  task automatic fin(input logic w, be, input logic [31:0] a,
                     input lbecu_size_type s);
    int k;
    int n;
    int sh;
    logic [63:0] bm;
    n = 1 << s;
    sh = be ? ((a[2:0] + n - 1) ^ 7) : a[2:0];
    bm = {64{1'b1}} >> (64 - 8 * n);
    k = 0;
    do begin
      @(negedge clock_i);
      k++;
    end while ((w ? wr_valid_o : load_valid_o) !== 1'b1 && k < 80);
    chk64("valid", 64'h1, {63'h0, w ? wr_valid_o : load_valid_o});
    if (w) begin
      chk64("lanes", {56'h0, 8'hff >> (8 - n) << sh}, {56'h0, wr_lanes_o});
      chk64("wdata", (WD & bm) << 8 * sh, wr_data_o & (bm << 8 * sh));
      chk64("waddr", {35'h0, a[31:3]}, {35'h0, wr_addr_o});
    end else
      chk64("rdata", (RD >> 8 * sh) & bm, load_data_o & bm);
  endtask

  task automatic xfer(input logic w, f, be, input logic [31:0] a,
                      input lbecu_size_type s);
    put(w, f, a, s);
    fin(w, be, a, s);
  endtask

  ////////////////////////////////////////
  task automatic s_mode();
    @(negedge clock_i);
    chk64("mode", 64'h0, {63'h0, big_endian_o});
    set_mode(1'b0, 1'b1);
    chk64("mode", 64'h0, {63'h0, big_endian_o});
    set_mode(1'b1, 1'b1);
    chk64("mode", 64'h1, {63'h0, big_endian_o});
  endtask

  task automatic s_steer(input logic be);
    logic [2:0] o;
    set_mode(1'b1, be);
    for (int s = 0; s < 4; s++) begin
      for (int j = 0; j < 2; j++) begin
        o = j ? 3'(8 - (1 << s)) : 3'h0;
        xfer(1'b1, 1'b0, be, {WA, o}, lbecu_size_type'(s));
        xfer(1'b0, 1'b0, be, {WA, o}, lbecu_size_type'(s));
      end
    end
  endtask

  task automatic s_back();
    xfer(1'b0, 1'b1, 1'b0, {WA, 3'h4}, LBECU_SZ_WORD);
    put(1'b0, 1'b0, {WA, 3'h0}, LBECU_SZ_DBL);
    fork
      fin(1'b0, 1'b1, {WA, 3'h0}, LBECU_SZ_DBL);
      put(1'b0, 1'b0, {WA, 3'h3}, LBECU_SZ_BYTE);
    join
    fork
      fin(1'b0, 1'b1, {WA, 3'h3}, LBECU_SZ_BYTE);
      put(1'b1, 1'b0, {WA, 3'h2}, LBECU_SZ_HALF);
    join
    fin(1'b1, 1'b1, {WA, 3'h2}, LBECU_SZ_HALF);
  endtask

  task automatic s_wait();
    @(posedge clock_i);
    wait_req_i <= 1'b1;
    fork
      xfer(1'b0, 1'b0, 1'b1, {WA, 3'h3}, LBECU_SZ_BYTE);
      begin
        repeat (6) @(posedge clock_i);
        wait_req_i <= 1'b0;
      end
    join
  endtask

  ////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    reset_n_i = 1'b0;
    {supervisor_i, set_endian_i, big_endian_sel_i} = 3'h0;
    {req_valid_i, req_write_i, req_fetch_i} = 3'h0;
    {req_same_page_i, req_pt_attr_i, wait_req_i} = 3'h0;
    req_addr_i = 32'h0;
    req_size_i = LBECU_SZ_BYTE;
    req_wdata_i = 64'h0;
    rd_data_i = RD;
    repeat (12) @(posedge clock_i);
    reset_n_i <= 1'b1;
    s_mode();
    s_steer(1'b0);
    s_steer(1'b1);
    s_back();
    s_wait();
    test_done();
  end
endmodule
